// file: bench/two_wire_bit_timing_props.sv
`timescale 1ns/1ps
`default_nettype none
`include "two_wire_timing_defs.vh"
module two_wire_bit_timing_props #(
  parameter FSR_W = `FSR_W
) (
  input wire logic                    clk_i,
  input wire logic                    nrst_i,
  input wire logic [`DIV_CODE_W-1:0]  divider_code_i,
  input wire logic [FSR_W-1:0]        filter_sample_rate_i,
  input wire logic                    bus_owned_o,
  input wire logic [`DIV_VALUE_W-1:0] divider_value_o,
  input wire logic                    scl_i,
  input wire logic                    scl_o,
  input wire logic                    scl_oe_o,
  input wire logic                    sda_o,
  input wire logic                    sda_oe_o,
  input wire logic                    scl_q_o
);
  // ==========================================================================
  // Phase counters
  logic [`CNT_W-1:0] lo_n, hi_n, dat_n, sda_n, in_n;
  logic              armed;
  wire  [`CNT_W-1:0] half = {1'b0, divider_value_o} >> 1;

  function automatic logic [`CNT_W-1:0] inc(input logic [`CNT_W-1:0] c);
    return (&c) ? c : c + 1'b1;
  endfunction

  function automatic logic [`CNT_W-1:0] shold(input logic [`DIV_VALUE_W-1:0] dv);
    logic [`CNT_W-1:0] q;
    q = {5'h00, dv[15:4]};
    while (q >= `START_HOLD_LIM)
      q = q >> 1;
    return (q == 17'h00000) ? 17'h00001 : q;
  endfunction

  function automatic logic [`CNT_W-1:0] dhold(input logic [5:0] c);
    logic [2:0] m;
    case ({c[5], c[1]})
      2'b10: m = 3'h1;
      2'b11: m = 3'h2;
      2'b00: m = 3'h3;
      default: m = 3'h4;
    endcase
    return `HOLD_BASE + ((`HOLD_UNIT << c[4:2]) * m);
  endfunction

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      lo_n  <= '0;
      hi_n  <= '0;
      dat_n <= '0;
      sda_n <= '0;
      in_n  <= '0;
      armed <= 1'b0;
    end else begin
      lo_n  <= scl_oe_o ? inc(lo_n) : '0;
      hi_n  <= scl_oe_o ? '0 : inc(hi_n);
      dat_n <= $changed(sda_oe_o) ? '0 : inc(dat_n);
      sda_n <= sda_oe_o ? inc(sda_n) : '0;
      in_n  <= scl_i ? inc(in_n) : '0;
      armed <= bus_owned_o && (armed || $fell(scl_oe_o));
    end
  end

  // ==========================================================================
  // Checks
  default clocking @(posedge clk_i); endclocking
  default disable iff (!nrst_i);

  sequence s_rs_edge;
    armed && $rose(sda_oe_o) && !scl_oe_o;
  endsequence

  a_pins_pull_only: assert property (scl_o == 1'b0 && sda_o == 1'b0 &&
    (bus_owned_o || (!scl_oe_o && !sda_oe_o)))
    else $error("pin driven high");
  a_scl_low_min: assert property ($fell(scl_oe_o) |-> lo_n >= half)
    else $error("scl low too short");
  a_scl_high_min: assert property (armed && $rose(scl_oe_o) |-> hi_n >= half)
    else $error("scl high too short");
  a_start_hold_min: assert property ($rose(scl_oe_o) && sda_oe_o |-> sda_n >= shold(divider_value_o))
    else $error("start hold too short");
  a_data_setup_min: assert property (bus_owned_o && $fell(scl_oe_o) |->
    dat_n + dhold(divider_code_i) + 2 >= half)
    else $error("data setup too short");
  a_rstart_setup: assert property (s_rs_edge |-> hi_n >= {1'b0, divider_value_o} + shold(divider_value_o))
    else $error("repeated start setup too short");
  a_stop_setup: assert property ($fell(sda_oe_o) && !scl_oe_o |-> hi_n >= `STOP_SETUP_MIN && hi_n >= half)
    else $error("stop setup too short");
  a_filter_lag: assert property ($rose(scl_q_o) |->
    in_n >= 2 * filter_sample_rate_i + 1 && in_n <= 2 * filter_sample_rate_i + 6)
    else $error("qualifier delay wrong");
  a_code_table: assert property ($past(nrst_i) && divider_code_i == 6'h20 && $past(divider_code_i) == 6'h20
    |-> divider_value_o == 16'h00A0)
    else $error("divider value wrong");
endmodule

bind two_wire_bit_timing two_wire_bit_timing_props #(.FSR_W(FSR_W)) i_two_wire_bit_timing_props (
  .clk_i(clk_i), .nrst_i(nrst_i), .divider_code_i(divider_code_i),
  .filter_sample_rate_i(filter_sample_rate_i), .bus_owned_o(bus_owned_o),
  .divider_value_o(divider_value_o), .scl_i(scl_i), .scl_o(scl_o), .scl_oe_o(scl_oe_o),
  .sda_o(sda_o), .sda_oe_o(sda_oe_o), .scl_q_o(scl_q_o)
);
`default_nettype wire

// file: bench/two_wire_bit_timing_test.sv
`timescale 1ns/1ps
`default_nettype none
`include "two_wire_timing_defs.vh"
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin fails++; \
  $display("[ERR] %0t got %0h exp %0h", $time, (a), (b)); end end
module two_wire_bit_timing_test;
  // ==========================================================================
  // Stimulus and wires
  logic                   clk_i = 1'b0;
  logic                   nrst_i = 1'b0;
  logic [`DIV_CODE_W-1:0] divider_code_i = 6'h20;
  logic [5:0]             filter_sample_rate_i = 6'h01;
  logic                   cmd_valid_i = 1'b0;
  logic [1:0]             cmd_i = 2'h0;
  logic                   cmd_data_i = 1'b0;
  logic                   hold_scl = 1'b0;
  logic                   hold_sda = 1'b0;
  logic                   last_rx = 1'b0;
  wire                    cmd_ready_o, done_o, rx_bit_o, rx_strobe_o, start_det_o, stop_det_o;
  wire                    bus_owned_o, scl_i, sda_i, scl_o, sda_o, scl_oe_o, sda_oe_o;
  wire                    scl_q_o, sda_q_o;
  wire [`DIV_VALUE_W-1:0] divider_value_o;
  int                     fails = 0, n_compared = 0, n_done = 0, n_rx = 0, n_st = 0, n_sp = 0;
  int                     hi_run = 0, last_hi = 0;

  always #20 clk_i = ~clk_i;

  two_wire_bit_timing i_two_wire_bit_timing (
    .clk_i, .nrst_i, .divider_code_i, .filter_sample_rate_i, .cmd_valid_i, .cmd_i, .cmd_data_i,
    .cmd_ready_o, .done_o, .rx_bit_o, .rx_strobe_o, .start_det_o, .stop_det_o, .bus_owned_o,
    .divider_value_o, .scl_i, .scl_o, .scl_oe_o, .sda_i, .sda_o, .sda_oe_o, .scl_q_o, .sda_q_o
  );
  two_wire_far_end i_two_wire_far_end (
    .scl_oe_i(scl_oe_o), .sda_oe_i(sda_oe_o), .hold_scl_low_i(hold_scl),
    .hold_sda_low_i(hold_sda), .scl_o(scl_i), .sda_o(sda_i)
  );

  // ==========================================================================
  // Pulse and line monitor
  always @(negedge clk_i) begin
    if (done_o === 1'b1) n_done++;
    if (start_det_o === 1'b1) n_st++;
    if (stop_det_o === 1'b1) n_sp++;
    if (rx_strobe_o === 1'b1) begin
      n_rx++;
      last_rx = rx_bit_o;
    end
    if (scl_i === 1'b1) hi_run++;
    else if (hi_run > 0) begin
      last_hi = hi_run;
      hi_run = 0;
    end
  end

  // ==========================================================================
  // Helpers
  task automatic tick(input int n);
    repeat (n) @(negedge clk_i);
  endtask

  task automatic issue(input logic [1:0] c, input logic d);
    int k;
    k = 0;
    while (cmd_ready_o !== 1'b1 && k < 5000) begin
      tick(1);
      k++;
    end
    cmd_i = c;
    cmd_data_i = d;
    cmd_valid_i = 1'b1;
    tick(1);
    cmd_valid_i = 1'b0;
  endtask

  task automatic wait_done(output int w);
    int n0;
    n0 = n_done;
    w = 0;
    while (n_done == n0 && w < 5000) begin
      tick(1);
      w++;
    end
    `CHK(n_done, n0 + 1)
  endtask

  // ==========================================================================
  // Scenarios
  task automatic t_lookup();
    logic [5:0]  c[9];
    logic [15:0] v[9];
    c = '{6'h20, 6'h00, 6'h1F, 6'h21, 6'h01, 6'h3F, 6'h2E, 6'h10, 6'h3E};
    v = '{16'h00A0, 16'h0120, 16'hF000, 16'h00C0, 16'h0140, 16'h8000, 16'h0780, 16'h1200,
          16'h7800};
    for (int i = 0; i < 9; i++) begin
      divider_code_i = c[i];
      tick(2);
      `CHK(divider_value_o, v[i])
    end
    divider_code_i = 6'h20;
    tick(3);
  endtask

  task automatic t_own_bus();
    int w, s0, p0;
    s0 = n_st;
    p0 = n_sp;
    issue(`CMD_START, 1'b0);
    wait_done(w);
    `CHK(n_st, s0 + 1)
    issue(`CMD_BIT, 1'b0);
    wait_done(w);
    `CHK(last_rx, 1'b0)
    fork
      begin
        tick(40);
        hold_scl = 1'b1;
        tick(300);
        hold_scl = 1'b0;
      end
    join_none
    issue(`CMD_BIT, 1'b1);
    wait_done(w);
    `CHK(w > 380, 1'b1)
    `CHK(last_rx, 1'b1)
    issue(2'h3, 1'b0);
    wait_done(w);
    `CHK(n_st, s0 + 2)
    issue(`CMD_STOP, 1'b0);
    wait_done(w);
    `CHK(n_sp, p0 + 1)
    `CHK({bus_owned_o, scl_i, sda_i}, 3'b011)
  endtask

  task automatic t_rate();
    int w, hi[2];
    for (int i = 0; i < 2; i++) begin
      divider_code_i = (i == 0) ? 6'h20 : 6'h21;
      tick(3);
      issue(`CMD_START, 1'b0);
      wait_done(w);
      issue(`CMD_BIT, 1'b1);
      wait_done(w);
      tick(2);
      hi[i] = last_hi;
      issue(`CMD_STOP, 1'b0);
      wait_done(w);
    end
    `CHK(hi[1] - hi[0], 16)
    `CHK(hi[0] >= 80, 1'b1)
    divider_code_i = 6'h20;
    tick(3);
  endtask

  task automatic t_ext_master();
    int lag[2];
    int s0, p0, r0;
    for (int i = 0; i < 2; i++) begin
      filter_sample_rate_i = (i == 0) ? 6'h01 : 6'h03;
      tick(20);
      hold_scl = 1'b1;
      lag[i] = 0;
      while (scl_q_o !== 1'b0 && lag[i] < 100) begin
        tick(1);
        lag[i]++;
      end
      hold_scl = 1'b0;
      tick(20);
    end
    `CHK(lag[1] - lag[0], 4)
    s0 = n_st;
    p0 = n_sp;
    r0 = n_rx;
    hold_sda = 1'b1;
    tick(20);
    `CHK(n_st, s0 + 1)
    `CHK({scl_q_o, sda_q_o}, 2'b10)
    hold_scl = 1'b1;
    tick(20);
    hold_sda = 1'b0;
    tick(20);
    hold_scl = 1'b0;
    tick(25);
    `CHK({n_rx == r0 + 1, last_rx}, 2'b11)
    hold_scl = 1'b1;
    tick(10);
    hold_sda = 1'b1;
    tick(10);
    hold_scl = 1'b0;
    tick(20);
    hold_sda = 1'b0;
    tick(25);
    `CHK(n_sp, p0 + 1)
    `CHK({scl_q_o, sda_q_o}, 2'b11)
    filter_sample_rate_i = 6'h01;
  endtask

  // ==========================================================================
  // Verdict
  task automatic results();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (8) @(negedge clk_i);
    nrst_i = 1'b1;
    tick(3);
    t_lookup();
    t_own_bus();
    t_rate();
    t_ext_master();
    results();
  end

  // Whole run needs well under 10000 cycles; this allows about 50000
  initial begin
    #2000000;
    fails++;
    $display("[ERR] %0t watchdog got %0h exp %0h", $time, 0, 1);
    results();
  end
endmodule
`default_nettype wire

// file: bench/two_wire_far_end.sv
`timescale 1ns/1ps
`default_nettype none
module two_wire_far_end (
  input  wire logic scl_oe_i,
  input  wire logic sda_oe_i,
  input  wire logic hold_scl_low_i,
  input  wire logic hold_sda_low_i,
  output logic      scl_o,
  output logic      sda_o
);
  // ==========================================================================
  // Open-drain lines with pull-ups, far side may stretch or drive
  assign scl_o = ~(scl_oe_i | hold_scl_low_i);
  assign sda_o = ~(sda_oe_i | hold_sda_low_i);
endmodule
`default_nettype wire

// file: hw/divider_lookup_rom.v
`timescale 1ns/1ps
`default_nettype none
`include "two_wire_timing_defs.vh"

module divider_lookup_rom (
  input  wire                      clk_i,
  input  wire                      nrst_i,
  input  wire [`DIV_CODE_W-1:0]    code_i,
  output reg  [`DIV_VALUE_W-1:0]   value_o
);

  // ==========================================================================
  // Registered table read
  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      value_o <= `DIV_RESET_VAL;
    end else begin
      case (code_i)
        6'h00: value_o <= 16'h0120;
        6'h01: value_o <= 16'h0140;
        6'h02: value_o <= 16'h0180;
        6'h03: value_o <= 16'h01C0;
        6'h04: value_o <= 16'h0240;
        6'h05: value_o <= 16'h0280;
        6'h06: value_o <= 16'h0300;
        6'h07: value_o <= 16'h0380;
        6'h08: value_o <= 16'h0480;
        6'h09: value_o <= 16'h0500;
        6'h0A: value_o <= 16'h0600;
        6'h0B: value_o <= 16'h0700;
        6'h0C: value_o <= 16'h0900;
        6'h0D: value_o <= 16'h0A00;
        6'h0E: value_o <= 16'h0C00;
        6'h0F: value_o <= 16'h0E00;
        6'h10: value_o <= 16'h1200;
        6'h11: value_o <= 16'h1400;
        6'h12: value_o <= 16'h1800;
        6'h13: value_o <= 16'h1C00;
        6'h14: value_o <= 16'h2400;
        6'h15: value_o <= 16'h2800;
        6'h16: value_o <= 16'h3000;
        6'h17: value_o <= 16'h3800;
        6'h18: value_o <= 16'h4800;
        6'h19: value_o <= 16'h5000;
        6'h1A: value_o <= 16'h6000;
        6'h1B: value_o <= 16'h7000;
        6'h1C: value_o <= 16'h9000;
        6'h1D: value_o <= 16'hA000;
        6'h1E: value_o <= 16'hC000;
        6'h1F: value_o <= 16'hF000;
        6'h20: value_o <= 16'h00A0;
        6'h21: value_o <= 16'h00C0;
        6'h22: value_o <= 16'h00E0;
        6'h23: value_o <= 16'h0100;
        6'h24: value_o <= 16'h0140;
        6'h25: value_o <= 16'h0180;
        6'h26: value_o <= 16'h01E0;
        6'h27: value_o <= 16'h0200;
        6'h28: value_o <= 16'h0280;
        6'h29: value_o <= 16'h0300;
        6'h2A: value_o <= 16'h03C0;
        6'h2B: value_o <= 16'h0400;
        6'h2C: value_o <= 16'h0500;
        6'h2D: value_o <= 16'h0600;
        6'h2E: value_o <= 16'h0780;
        6'h2F: value_o <= 16'h0800;
        6'h30: value_o <= 16'h0A00;
        6'h31: value_o <= 16'h0C00;
        6'h32: value_o <= 16'h0F00;
        6'h33: value_o <= 16'h1000;
        6'h34: value_o <= 16'h1400;
        6'h35: value_o <= 16'h1800;
        6'h36: value_o <= 16'h1E00;
        6'h37: value_o <= 16'h2000;
        6'h38: value_o <= 16'h2800;
        6'h39: value_o <= 16'h3000;
        6'h3A: value_o <= 16'h3C00;
        6'h3B: value_o <= 16'h4000;
        6'h3C: value_o <= 16'h5000;
        6'h3D: value_o <= 16'h6000;
        6'h3E: value_o <= 16'h7800;
        default: value_o <= 16'h8000;
      endcase
    end
  end

endmodule

`default_nettype wire

// file: hw/two_wire_bit_timing.v
// Notes on behaviour
// - The divider value is looked up from a fixed 64-entry table by the divider code.
// - All six code bits index the table; the result drives every output timing except data hold, which decodes the code bits, and the qualifier delay.
// - A driven SCL stays low for at least half the divider value and high for the same.
// - Start hold is divider/16 halved until it falls below 16.
// - As master, SDA changes one data-hold time into the low phase, leaving the setup.
// - Repeated-start setup lasts the divider value plus the start hold time.
// - Stop setup lasts at least four system clocks.
// - Sampled SCL and SDA are delayed by twice the sample-rate field plus one clock.
// - Every divider-derived time is counted in system clocks.
// - The pins are only pulled low or released; pull-ups give the high level.
// - Each divider value gives its own bit rate even where input limits match.
`timescale 1ns/1ps
`default_nettype none
`include "two_wire_timing_defs.vh"

module two_wire_bit_timing #(
  parameter FSR_W = `FSR_W
) (
  input  wire                      clk_i,
  input  wire                      nrst_i,
  input  wire [`DIV_CODE_W-1:0]    divider_code_i,
  input  wire [FSR_W-1:0]          filter_sample_rate_i,
  input  wire                      cmd_valid_i,
  input  wire [1:0]                cmd_i,
  input  wire                      cmd_data_i,
  output wire                      cmd_ready_o,
  output reg                       done_o,
  output reg                       rx_bit_o,
  output reg                       rx_strobe_o,
  output reg                       start_det_o,
  output reg                       stop_det_o,
  output wire                      bus_owned_o,
  output wire [`DIV_VALUE_W-1:0]   divider_value_o,
  input  wire                      scl_i,
  output wire                      scl_o,
  output reg                       scl_oe_o,
  input  wire                      sda_i,
  output wire                      sda_o,
  output reg                       sda_oe_o,
  output reg                       scl_q_o,
  output reg                       sda_q_o
);

  localparam DLY_LEN = 2 * ((1 << FSR_W) - 1) + 1;

  // ==========================================================================
  // Timing functions
  function [`CNT_W-1:0] hold_time;
    input [`DIV_CODE_W-1:0] code;
    reg   [`CNT_W-1:0]      unit;
    reg   [2:0]             k;
    begin
      unit = `HOLD_UNIT << code[`DC_EXP_MSB:`DC_EXP_LSB];
      case ({code[`DC_BIT_HI], code[`DC_BIT_LO]})
        2'h2:    k = 3'h4;
        2'h3:    k = 3'h3;
        2'h0:    k = 3'h2;
        default: k = 3'h1;
      endcase
      hold_time = `HOLD_BASE + unit * {14'h0000, 3'h5 - k};
    end
  endfunction

  function [`CNT_W-1:0] start_hold;
    input [`DIV_VALUE_W-1:0] dv;
    reg   [`CNT_W-1:0]       q;
    integer                  i;
    begin
      q = {5'h00, dv[`DIV_VALUE_W-1:4]};
      for (i = 0; i < 12; i = i + 1) begin
        if (q >= `START_HOLD_LIM) begin
          q = q >> 1;
        end
      end
      start_hold = (q == 17'h00000) ? 17'h00001 : q;
    end
  endfunction

  function [`CNT_W-1:0] at_least;
    input [`CNT_W-1:0] a;
    input [`CNT_W-1:0] b;
    begin
      at_least = (a > b) ? a : b;
    end
  endfunction

  // ==========================================================================
  // Divider lookup
  wire [`DIV_VALUE_W-1:0] divider_value;

  divider_lookup_rom u_rom (
    .clk_i   (clk_i),
    .nrst_i  (nrst_i),
    .code_i  (divider_code_i),
    .value_o (divider_value)
  );

  assign divider_value_o = divider_value;

  wire [`CNT_W-1:0] half_cnt  = at_least({2'h0, divider_value[`DIV_VALUE_W-1:1]}, 17'h00001);
  wire [`CNT_W-1:0] hold_cnt  = hold_time(divider_code_i);
  wire [`CNT_W-1:0] shold_cnt = start_hold(divider_value);
  wire [`CNT_W-1:0] rs_cnt    = {1'b0, divider_value} + shold_cnt;
  wire [`CNT_W-1:0] stop_cnt  = at_least(half_cnt, `STOP_SETUP_MIN);
  wire [`CNT_W-1:0] chg_pt    = (hold_cnt < half_cnt) ? hold_cnt : half_cnt - 17'h00001;

  // ==========================================================================
  // Pin synchronisers
  reg [`SYNC_STAGES-1:0] scl_sync;
  reg [`SYNC_STAGES-1:0] sda_sync;
  reg                    scl_clean;
  reg                    sda_clean;

  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      scl_sync  <= 3'h7;
      sda_sync  <= 3'h7;
      scl_clean <= 1'b1;
      sda_clean <= 1'b1;
    end else begin
      scl_sync <= {scl_sync[1:0], scl_i};
      sda_sync <= {sda_sync[1:0], sda_i};
      if (scl_sync[1] == scl_sync[2]) begin
        scl_clean <= scl_sync[2];
      end
      if (sda_sync[1] == sda_sync[2]) begin
        sda_clean <= sda_sync[2];
      end
    end
  end

  // ==========================================================================
  // Qualifying delay line
  reg [DLY_LEN-1:0] scl_dly;
  reg [DLY_LEN-1:0] sda_dly;

  genvar g;
  generate
    for (g = 0; g < DLY_LEN; g = g + 1) begin : g_dly
      wire scl_prev;
      wire sda_prev;
      if (g == 0) begin : g_head
        assign scl_prev = scl_clean;
        assign sda_prev = sda_clean;
      end else begin : g_tail
        assign scl_prev = scl_dly[g-1];
        assign sda_prev = sda_dly[g-1];
      end
      always @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
          scl_dly[g] <= 1'b1;
          sda_dly[g] <= 1'b1;
        end else begin
          scl_dly[g] <= scl_prev;
          sda_dly[g] <= sda_prev;
        end
      end
    end
  endgenerate

  wire [FSR_W:0] tap = {filter_sample_rate_i, 1'b0};

  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      scl_q_o <= 1'b1;
      sda_q_o <= 1'b1;
    end else if (tap == {(FSR_W+1){1'b0}}) begin
      scl_q_o <= scl_clean;
      sda_q_o <= sda_clean;
    end else begin
      scl_q_o <= scl_dly[tap-1'b1];
      sda_q_o <= sda_dly[tap-1'b1];
    end
  end

  // ==========================================================================
  // Bus event detection on qualified signals
  reg scl_q_d;
  reg sda_q_d;

  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      scl_q_d     <= 1'b1;
      sda_q_d     <= 1'b1;
      rx_bit_o    <= 1'b0;
      rx_strobe_o <= 1'b0;
      start_det_o <= 1'b0;
      stop_det_o  <= 1'b0;
    end else begin
      scl_q_d     <= scl_q_o;
      sda_q_d     <= sda_q_o;
      rx_strobe_o <= scl_q_o & ~scl_q_d;
      start_det_o <= scl_q_o & scl_q_d & sda_q_d & ~sda_q_o;
      stop_det_o  <= scl_q_o & scl_q_d & ~sda_q_d & sda_q_o;
      if (scl_q_o && !scl_q_d) begin
        rx_bit_o <= sda_q_o;
      end
    end
  end

  // ==========================================================================
  // Master sequencer
  reg [3:0]         state;
  reg [1:0]         mode;
  reg [`CNT_W-1:0]  cnt;
  reg               bit_val;

  assign scl_o       = 1'b0;
  assign sda_o       = 1'b0;
  assign cmd_ready_o = (state == `ST_IDLE) || (state == `ST_PARK);
  assign bus_owned_o = (state != `ST_IDLE);

  wire take = cmd_valid_i && cmd_ready_o;

  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state    <= `ST_IDLE;
      mode     <= `MODE_BIT;
      cnt      <= 17'h00000;
      bit_val  <= 1'b1;
      scl_oe_o <= 1'b0;
      sda_oe_o <= 1'b0;
      done_o   <= 1'b0;
    end else begin
      done_o <= 1'b0;
      cnt    <= cnt + 17'h00001;
      case (state)
        `ST_IDLE: begin
          scl_oe_o <= 1'b0;
          sda_oe_o <= 1'b0;
          if (take && cmd_i == `CMD_START) begin
            sda_oe_o <= 1'b1;
            cnt      <= 17'h00000;
            state    <= `ST_START;
          end
        end
        `ST_START: begin
          if (cnt >= shold_cnt - 17'h00001) begin
            scl_oe_o <= 1'b1;
            done_o   <= 1'b1;
            state    <= `ST_PARK;
          end
        end
        `ST_PARK: begin
          scl_oe_o <= 1'b1;
          if (take) begin
            cnt   <= 17'h00000;
            state <= `ST_LOW;
            case (cmd_i)
              `CMD_BIT: begin
                mode    <= `MODE_BIT;
                bit_val <= cmd_data_i;
              end
              `CMD_STOP: begin
                mode    <= `MODE_STOP;
                bit_val <= 1'b0;
              end
              default: begin
                mode    <= `MODE_RSTART;
                bit_val <= 1'b1;
              end
            endcase
          end
        end
        `ST_LOW: begin
          if (cnt == chg_pt) begin
            sda_oe_o <= ~bit_val;
          end
          if (cnt >= half_cnt - 17'h00001) begin
            scl_oe_o <= 1'b0;
            state    <= `ST_HIGH_WAIT;
          end
        end
        `ST_HIGH_WAIT: begin
          cnt <= 17'h00000;
          if (scl_q_o) begin
            case (mode)
              `MODE_RSTART: state <= `ST_RS_SETUP;
              `MODE_STOP:   state <= `ST_STOP_SETUP;
              default:      state <= `ST_HIGH;
            endcase
          end
        end
        `ST_HIGH: begin
          if (cnt >= half_cnt - 17'h00001) begin
            scl_oe_o <= 1'b1;
            done_o   <= 1'b1;
            state    <= `ST_PARK;
          end
        end
        `ST_RS_SETUP: begin
          if (cnt >= rs_cnt - 17'h00001) begin
            sda_oe_o <= 1'b1;
            cnt      <= 17'h00000;
            state    <= `ST_START;
          end
        end
        `ST_STOP_SETUP: begin
          if (cnt >= stop_cnt - 17'h00001) begin
            sda_oe_o <= 1'b0;
            cnt      <= 17'h00000;
            state    <= `ST_STOP_HIGH;
          end
        end
        `ST_STOP_HIGH: begin
          if (cnt >= half_cnt - 17'h00001) begin
            done_o <= 1'b1;
            state  <= `ST_IDLE;
          end
        end
        default: begin
          scl_oe_o <= 1'b0;
          sda_oe_o <= 1'b0;
          state    <= `ST_IDLE;
        end
      endcase
    end
  end

endmodule

`default_nettype wire

// file: hw/two_wire_timing_defs.vh
`ifndef TWO_WIRE_TIMING_DEFS_VH
`define TWO_WIRE_TIMING_DEFS_VH

// ==========================================================================
// Widths
`define DIV_CODE_W     6
`define DIV_VALUE_W    16
`define FSR_W          6
`define CNT_W          17

// ==========================================================================
// Divider code fields
`define DC_BIT_HI      5
`define DC_BIT_LO      1
`define DC_EXP_MSB     4
`define DC_EXP_LSB     2

// ==========================================================================
// Timing constants in system clocks
`define HOLD_BASE      17'h00008
`define HOLD_UNIT      17'h00010
`define STOP_SETUP_MIN 17'h00004
`define START_HOLD_LIM 17'h00010
`define SYNC_STAGES    3
`define DIV_RESET_VAL  16'h0120

// ==========================================================================
// Commands
`define CMD_START      2'h0
`define CMD_BIT        2'h1
`define CMD_STOP       2'h2

// ==========================================================================
// Sequence modes
`define MODE_BIT       2'h0
`define MODE_RSTART    2'h1
`define MODE_STOP      2'h2

// ==========================================================================
// States
`define ST_IDLE        4'h0
`define ST_START       4'h1
`define ST_LOW         4'h2
`define ST_HIGH_WAIT   4'h3
`define ST_HIGH        4'h4
`define ST_PARK        4'h5
`define ST_RS_SETUP    4'h6
`define ST_STOP_SETUP  4'h7
`define ST_STOP_HIGH   4'h8

`endif
